// *** pkg/rpd_pkg.sv ***
// Types shared by the reset and power-down controller
`default_nettype none

package rpd_pkg;

   // Gray order along run -> idle -> power-down -> wake and through the reset path
   typedef enum logic [2:0] {
      ST_RUN       = 3'h0,
      ST_IDLE      = 3'h1,
      ST_PD_INT    = 3'h3,
      ST_WAKE      = 3'h2,
      ST_RST_SYNC  = 3'h6,
      ST_RST_WAIT  = 3'h7,
      ST_RST_ASYNC = 3'h5,
      ST_PD_PROT   = 3'h4
   } rpd_state_e;

endpackage

`default_nettype wire

// *** pkg/rpd_regs.svh ***
// Register offsets, field positions and timing constants of the reset and power-down controller
`ifndef RPD_REGS_SVH
`define RPD_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define RPD_ADDR_W        8
`define RPD_OFS_CFG       8'h00
`define RPD_OFS_STAT      8'h04
`define RPD_OFS_FLAG      8'h08
`define RPD_CFG_PDCFG     0
`define RPD_CFG_BDREN     5
`define RPD_STAT_STATE    0
`define RPD_STAT_RST_OUT  3
`define RPD_STAT_PULLUP   4
`define RPD_STAT_FLAG     8
`define RPD_NUM_EXT       8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RPD_CLK_NS        50
`define RPD_TCL_PER_CLK   2
`define RPD_RST_SEQ_TCL   1024
`define RPD_RST_SEQ_CYC   (`RPD_RST_SEQ_TCL / `RPD_TCL_PER_CLK)
`define RPD_WAKE_MIN_NS   40
`define RPD_WAKE_CYC      ((`RPD_WAKE_MIN_NS + `RPD_CLK_NS - 1) / `RPD_CLK_NS)
`define RPD_OSC_WAIT_CYC  16
`define RPD_CNT_W         10

`endif

// *** src/rpd_ctrl.sv ***
// Reset pin, wake-capacitor pin and idle / power-down controller with an APB register slave
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`default_nettype none
`include "rpd_regs.svh"

// Notes on behaviour
// - Idle stops the CPU only; a low reset pin or an interrupt request ends it, watchdog and software requests do not.
// - Power-down stops CPU and peripheral clocks.
// - Protected power-down is entered only while the NMI pin is still low.
// - Protected power-down is left only by a hardware reset.
// - Interruptible power-down also stops oscillator and PLL.
// - A valid wake restarts oscillator and PLL and turns on the wake-pin pulldown.
// - Enabled waking interrupt is serviced, then execution resumes.
// - Disabled waking interrupt leaves its flag set until software clears it.
// - Pending external bus actions finish before idle or power-down.
// - No entry when READY is enabled but was not seen on the last access.
// - Reset output stays low after reset until end of initialisation.
// - With bidirectional enable set, sync, watchdog and software resets pull reset pin low.
// - With power-down config set, wake pin pullup is on except during a reset sequence, which clears the config.
// - Wake pin pulldown is on whenever the reset input pin is low.
// - Short reset pulse with wake pin high gives a synchronous reset.
// - Reset held until wake pin discharges gives an asynchronous reset.
// - Bidirectional enable is bit 5 of the config register, cleared by every reset.
// - Low reset pin: synchronous if wake pin high, asynchronous if low.
module rpd_ctrl
   import rpd_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    reset,
   input  wire logic                    clk_en,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`RPD_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]             pwdata,
   output var  logic [31:0]             prdata,
   output var  logic                    pready,
   output var  logic                    pslverr,
   input  wire logic                    reset_input_pin_in,
   output var  logic                    reset_input_pin_out,
   output var  logic                    reset_input_pin_oe,
   input  wire logic                    wake_cap_pin_in,
   output var  logic                    wake_cap_pullup_en,
   output var  logic                    wake_cap_pulldown_en,
   input  wire logic                    nmi_pin_n_in,
   input  wire logic [`RPD_NUM_EXT-1:0] fast_ext_irq_pin,
   input  wire logic [`RPD_NUM_EXT-1:0] ext_irq_enable,
   input  wire logic                    irq_request,
   input  wire logic                    idle_instr,
   input  wire logic                    power_down_instr,
   input  wire logic                    end_of_init_instr,
   input  wire logic                    wdt_reset_req,
   input  wire logic                    sw_reset_req,
   input  wire logic                    bus_busy,
   input  wire logic                    ready_enabled,
   input  wire logic                    ready_seen,
   output var  logic                    reset_output_pin,
   output var  logic                    sys_reset,
   output var  logic                    cpu_clk_stop,
   output var  logic                    periph_clk_stop,
   output var  logic                    osc_pll_stop,
   output var  logic                    wake_service_req,
   output var  logic [2:0]              wake_service_idx,
   output var  logic                    resume_pulse,
   output var  logic                    entry_refused
);

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic logic in_reset(input rpd_state_e s);
      return (s == ST_RST_SYNC) || (s == ST_RST_WAIT) || (s == ST_RST_ASYNC);
   endfunction

   function automatic logic in_pd(input rpd_state_e s);
      return (s == ST_PD_INT) || (s == ST_PD_PROT);
   endfunction

   function automatic logic mapped(input logic [`RPD_ADDR_W-1:0] a);
      return (a == `RPD_OFS_CFG) || (a == `RPD_OFS_STAT) || (a == `RPD_OFS_FLAG);
   endfunction

   function automatic logic [2:0] first_set(input logic [`RPD_NUM_EXT-1:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = `RPD_NUM_EXT - 1; i >= 0; i--) begin
         if (v[i]) r = 3'(i);
      end
      return r;
   endfunction

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   logic [`RPD_NUM_EXT+2:0] pins_s;
   logic                    rst_pin_low;
   logic                    cap_high;
   logic                    nmi_high;
   logic [`RPD_NUM_EXT-1:0] ext_s;

   rpd_sync #(
      .W    (`RPD_NUM_EXT + 3),
      .INIT ({3'h7, `RPD_NUM_EXT'h00})
   ) u_sync (
      .clock  (clock),
      .reset  (reset),
      .clk_en (clk_en),
      .d      ({reset_input_pin_in, wake_cap_pin_in, nmi_pin_n_in, fast_ext_irq_pin}),
      .q      (pins_s)
   );

   assign rst_pin_low = !pins_s[`RPD_NUM_EXT+2];
   assign cap_high    = pins_s[`RPD_NUM_EXT+1];
   assign nmi_high    = pins_s[`RPD_NUM_EXT];
   assign ext_s       = pins_s[`RPD_NUM_EXT-1:0];

   // -------------------------------------------------------------------------
   // Control state
   // -------------------------------------------------------------------------
   rpd_state_e              state_reg,   state_next;
   logic [`RPD_CNT_W-1:0]   cnt_reg,     cnt_next;
   logic                    pdcfg_reg,   pdcfg_next;
   logic                    bdren_reg,   bdren_next;
   logic                    bdr_reg,     bdr_next;
   logic                    pend_i_reg,  pend_i_next;
   logic                    pend_p_reg,  pend_p_next;
   logic                    wake_pd_reg, wake_pd_next;
   logic [2:0]              idx_next;
   logic [`RPD_NUM_EXT-1:0] flag_reg,    flag_next;
   logic                    reset_output_pin_next;
   logic                    svc_next;
   logic                    resume_next;
   logic                    refused_next;
   logic                    wr_cfg;
   logic                    wr_flag;

   assign wr_cfg  = psel && penable && pwrite && pready && (paddr == `RPD_OFS_CFG);
   assign wr_flag = psel && penable && pwrite && pready && (paddr == `RPD_OFS_FLAG);

   always_comb begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      pdcfg_next   = pdcfg_reg;
      bdren_next   = bdren_reg;
      bdr_next     = bdr_reg;
      pend_i_next  = pend_i_reg;
      pend_p_next  = pend_p_reg;
      wake_pd_next = wake_pd_reg;
      idx_next     = wake_service_idx;
      flag_next    = flag_reg;
      reset_output_pin_next  = reset_output_pin;
      svc_next     = 1'b0;
      resume_next  = 1'b0;
      refused_next = 1'b0;
      if (wr_cfg) begin
         pdcfg_next = pwdata[`RPD_CFG_PDCFG];
         bdren_next = pwdata[`RPD_CFG_BDREN];
      end
      if (wr_flag) begin
         flag_next = flag_reg & ~pwdata[`RPD_NUM_EXT-1:0];
      end
      unique case (state_reg)
         ST_RUN: begin
            if (end_of_init_instr) begin
               reset_output_pin_next = 1'b1;
            end
            if (wdt_reset_req || sw_reset_req) begin
               state_next = ST_RST_SYNC;
            end else begin
               if (idle_instr || power_down_instr) begin
                  if (ready_enabled && !ready_seen) begin
                     refused_next = 1'b1;
                  end else if (power_down_instr && !pdcfg_reg && nmi_high) begin
                     refused_next = 1'b1;
                  end else begin
                     pend_i_next = idle_instr;
                     pend_p_next = power_down_instr;
                  end
               end
               // Entry waits for the external bus to drain
               if ((pend_i_next || pend_p_next) && !bus_busy) begin
                  if (pend_p_next) begin
                     state_next = pdcfg_reg ? ST_PD_INT : ST_PD_PROT;
                  end else begin
                     state_next = ST_IDLE;
                  end
                  pend_i_next = 1'b0;
                  pend_p_next = 1'b0;
                  cnt_next    = '0;
               end
            end
         end
         ST_IDLE: begin
            if (irq_request) begin
               state_next  = ST_RUN;
               resume_next = 1'b1;
            end
         end
         ST_PD_PROT: begin
            state_next = ST_PD_PROT;
         end
         ST_PD_INT: begin
            if (|ext_s) begin
               if (cnt_reg >= `RPD_CNT_W'(`RPD_WAKE_CYC - 1)) begin
                  state_next   = ST_WAKE;
                  wake_pd_next = 1'b1;
                  idx_next     = first_set(ext_s);
                  cnt_next     = '0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end else begin
               cnt_next = '0;
            end
         end
         ST_WAKE: begin
            // Oscillator and PLL get a settling time before the resume pulse; CPU and peripheral clocks already run during it
            if (cnt_reg == `RPD_CNT_W'(`RPD_OSC_WAIT_CYC - 1)) begin
               state_next  = ST_RUN;
               resume_next = 1'b1;
               if (ext_irq_enable[wake_service_idx]) begin
                  svc_next = 1'b1;
               end
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         ST_RST_SYNC: begin
            if (cnt_reg == `RPD_CNT_W'(`RPD_RST_SEQ_CYC - 1)) begin
               state_next = ST_RST_WAIT;
               bdr_next   = 1'b0;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         ST_RST_WAIT: begin
            if (!rst_pin_low) begin
               state_next = ST_RUN;
            end
         end
         ST_RST_ASYNC: begin
            if (!rst_pin_low) begin
               state_next = ST_RUN;
            end
         end
      endcase
      // Reset pin outranks every mode; our own pulldown must not retrigger a sequence
      if (rst_pin_low && !cap_high) begin
         state_next = ST_RST_ASYNC;
      end else if (rst_pin_low && !in_reset(state_reg)) begin
         state_next = ST_RST_SYNC;
      end
      if (in_reset(state_next) && !in_reset(state_reg)) begin
         bdr_next     = (state_next == ST_RST_SYNC) && bdren_reg;
         cnt_next     = '0;
         pend_i_next  = 1'b0;
         pend_p_next  = 1'b0;
         wake_pd_next = 1'b0;
         reset_output_pin_next  = 1'b0;
      end
      if (in_reset(state_next)) begin
         pdcfg_next = 1'b0;
         bdren_next = 1'b0;
      end
      if (state_next == ST_RST_ASYNC) begin
         bdr_next = 1'b0;
      end
      // Hardware set wins over a software clear in the same cycle
      if (state_reg == ST_WAKE && resume_next && !ext_irq_enable[wake_service_idx]) begin
         flag_next[wake_service_idx] = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg            <= ST_RUN;
         cnt_reg              <= '0;
         pdcfg_reg            <= 1'b0;
         bdren_reg            <= 1'b0;
         bdr_reg              <= 1'b0;
         pend_i_reg           <= 1'b0;
         pend_p_reg           <= 1'b0;
         wake_pd_reg          <= 1'b0;
         flag_reg             <= '0;
         wake_service_idx     <= 3'h0;
         reset_output_pin     <= 1'b0;
         wake_service_req     <= 1'b0;
         resume_pulse         <= 1'b0;
         entry_refused        <= 1'b0;
         sys_reset            <= 1'b0;
         cpu_clk_stop         <= 1'b0;
         periph_clk_stop      <= 1'b0;
         osc_pll_stop         <= 1'b0;
         reset_input_pin_out  <= 1'b0;
         reset_input_pin_oe   <= 1'b0;
         wake_cap_pullup_en   <= 1'b0;
         wake_cap_pulldown_en <= 1'b0;
      end else if (clk_en) begin
         state_reg            <= state_next;
         cnt_reg              <= cnt_next;
         pdcfg_reg            <= pdcfg_next;
         bdren_reg            <= bdren_next;
         bdr_reg              <= bdr_next;
         pend_i_reg           <= pend_i_next;
         pend_p_reg           <= pend_p_next;
         wake_pd_reg          <= wake_pd_next;
         flag_reg             <= flag_next;
         wake_service_idx     <= idx_next;
         reset_output_pin     <= reset_output_pin_next;
         wake_service_req     <= svc_next;
         resume_pulse         <= resume_next;
         entry_refused        <= refused_next;
         sys_reset            <= in_reset(state_next);
         cpu_clk_stop         <= (state_next == ST_IDLE) || in_pd(state_next);
         periph_clk_stop      <= in_pd(state_next);
         osc_pll_stop         <= (state_next == ST_PD_INT);
         reset_input_pin_out  <= 1'b0;
         reset_input_pin_oe   <= bdr_next && (state_next == ST_RST_SYNC);
         wake_cap_pullup_en   <= pdcfg_next && !in_reset(state_next);
         wake_cap_pulldown_en <= rst_pin_low || wake_pd_next;
      end
   end

   // -------------------------------------------------------------------------
   // APB slave, zero wait states; read data is captured in the setup cycle
   // -------------------------------------------------------------------------
   logic [31:0] prdata_next;
   logic        pready_next;
   logic        pslverr_next;

   always_comb begin
      prdata_next  = prdata;
      pready_next  = psel && !penable;
      pslverr_next = 1'b0;
      if (psel && !penable) begin
         pslverr_next = !mapped(paddr);
         prdata_next  = 32'h0;
         if (paddr == `RPD_OFS_CFG) begin
            prdata_next[`RPD_CFG_PDCFG] = pdcfg_reg;
            prdata_next[`RPD_CFG_BDREN] = bdren_reg;
         end else if (paddr == `RPD_OFS_STAT) begin
            prdata_next[`RPD_STAT_STATE +: 3] = state_reg;
            prdata_next[`RPD_STAT_RST_OUT]    = reset_output_pin;
            prdata_next[`RPD_STAT_PULLUP]     = wake_cap_pullup_en;
         end else if (paddr == `RPD_OFS_FLAG) begin
            prdata_next[`RPD_STAT_FLAG +: `RPD_NUM_EXT] = flag_reg;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         prdata  <= prdata_next;
         pready  <= pready_next;
         pslverr <= pslverr_next;
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   property p_idle_exit;
      @(posedge clock) disable iff (reset || !clk_en)
      (state_reg == ST_IDLE && irq_request && !rst_pin_low) |=> (state_reg == ST_RUN);
   endproperty
   a_idle_exit: assert property (p_idle_exit) else $error("idle not left on interrupt");

   property p_pd_stop;
      @(posedge clock) disable iff (reset || !clk_en)
      in_pd(state_reg) |-> (cpu_clk_stop && periph_clk_stop);
   endproperty
   a_pd_stop: assert property (p_pd_stop) else $error("clocks run in power-down");

   property p_prot_refuse;
      @(posedge clock) disable iff (reset || !clk_en)
      (state_reg == ST_RUN && power_down_instr && !pdcfg_reg && nmi_high && !rst_pin_low)
         |=> (state_reg != ST_PD_PROT) && entry_refused;
   endproperty
   a_prot_refuse: assert property (p_prot_refuse) else $error("protected entry with nmi high");

   property p_prot_hold;
      @(posedge clock) disable iff (reset || !clk_en)
      (state_reg == ST_PD_PROT && !rst_pin_low) |=> (state_reg == ST_PD_PROT);
   endproperty
   a_prot_hold: assert property (p_prot_hold) else $error("protected power-down left early");

   property p_osc_stop;
      @(posedge clock) disable iff (reset || !clk_en)
      (state_reg == ST_PD_INT) |-> osc_pll_stop;
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("oscillator runs in power-down");

   property p_wake;
      @(posedge clock) disable iff (reset || !clk_en)
      (state_reg == ST_PD_INT && (|ext_s) && !rst_pin_low)
         |=> (!osc_pll_stop && wake_cap_pulldown_en && state_reg == ST_WAKE);
   endproperty
   a_wake: assert property (p_wake) else $error("wake did not restart oscillator");

   property p_bus_drain;
      @(posedge clock) disable iff (reset || !clk_en)
      (state_reg == ST_RUN && bus_busy && !rst_pin_low && !wdt_reset_req && !sw_reset_req)
         |=> (state_reg == ST_RUN);
   endproperty
   a_bus_drain: assert property (p_bus_drain) else $error("entered low power with bus busy");

   property p_ready_refuse;
      @(posedge clock) disable iff (reset || !clk_en)
      (state_reg == ST_RUN && idle_instr && ready_enabled && !ready_seen && !rst_pin_low)
         |=> entry_refused ##1 (state_reg == ST_RUN);
   endproperty
   a_ready_refuse: assert property (p_ready_refuse) else $error("entry despite missing READY");

   property p_reset_out;
      @(posedge clock) disable iff (reset || !clk_en)
      (state_reg == ST_RUN && end_of_init_instr && !rst_pin_low && !wdt_reset_req && !sw_reset_req)
         |=> reset_output_pin;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("reset output not raised");

   property p_sync_entry;
      @(posedge clock) disable iff (reset || !clk_en)
      (state_reg == ST_RUN && rst_pin_low && cap_high) |=> (state_reg == ST_RST_SYNC) && sys_reset;
   endproperty
   a_sync_entry: assert property (p_sync_entry) else $error("no synchronous reset");

   property p_pin_pulldown;
      @(posedge clock) disable iff (reset || !clk_en)
      rst_pin_low |=> wake_cap_pulldown_en;
   endproperty
   a_pin_pulldown: assert property (p_pin_pulldown) else $error("wake pulldown off");

endmodule

`default_nettype wire

// *** src/rpd_sync.sv ***
// Three-stage pin synchroniser that passes a change once stages two and three agree
`default_nettype none

module rpd_sync #(
   parameter int unsigned    W    = 1,
   parameter logic [W-1:0]   INIT = '0
) (
   input  wire logic         clock,
   input  wire logic         reset,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_next;

   always_comb begin
      for (int i = 0; i < W; i++) begin
         q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q[i];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
         q      <= INIT;
      end else if (clk_en) begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q      <= q_next;
      end
   end

endmodule

`default_nettype wire

// *** verification/rpd_ctrl_tb_top.sv ***
// Self-checking bench for the reset and power-down controller
`default_nettype none
module rpd_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // Stimulus
   // ----
   logic clock = 0, reset = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0, ext_irq_enable = 0, fast_ext_irq_pin;
   logic [31:0] pwdata = 0, prdata, rd;
   logic nmi_pin_n_in = 1, irq_request = 0, idle_instr = 0, power_down_instr = 0;
   logic end_of_init_instr = 0, wdt_reset_req = 0, sw_reset_req = 0, bus_busy = 0;
   logic ready_enabled = 0, ready_seen = 0, rst_low = 0, cap_low = 0, wk_go = 0;
   logic [2:0] wk_idx = 0, wake_service_idx, seen = 0;
   logic pready, pslverr, reset_input_pin_in, reset_input_pin_out, reset_input_pin_oe;
   logic wake_cap_pin_in, wake_cap_pullup_en, wake_cap_pulldown_en, reset_output_pin;
   logic sys_reset, cpu_clk_stop, periph_clk_stop, osc_pll_stop, wake_service_req;
   logic resume_pulse, entry_refused, err;
   int error_cnt = 0, checked = 0;
   always #25 clock = ~clock;
   // One-cycle pulses would be missed between checks
   always @(posedge clock) seen <= seen | {wake_service_req, resume_pulse, entry_refused};
   rpd_ctrl u_rpd_ctrl (.*);
   rpd_far u_rpd_far (.rst_low(rst_low), .rst_oe(reset_input_pin_oe), .cap_low(cap_low),
      .wk_go(wk_go), .wk_idx(wk_idx), .rst_pin(reset_input_pin_in),
      .cap_pin(wake_cap_pin_in), .fast(fast_ext_irq_pin));
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      // Idle edge so the next setup never reassigns psel in this time step
      @(posedge clock);
   endtask
   localparam int P_IDLE = 0, P_PD = 1, P_EOI = 2, P_IRQ = 3, P_WDT = 4, P_SW = 5;
   task automatic pulse(int k);
      case (k)
         P_IDLE: idle_instr <= 1;
         P_PD: power_down_instr <= 1;
         P_EOI: end_of_init_instr <= 1;
         P_IRQ: irq_request <= 1;
         P_WDT: wdt_reset_req <= 1;
         default: sw_reset_req <= 1;
      endcase
      @(posedge clock);
      {idle_instr, power_down_instr, end_of_init_instr} <= '0;
      {irq_request, wdt_reset_req, sw_reset_req} <= '0;
      repeat (6) @(posedge clock);
   endtask
   task automatic wake(logic [2:0] i);
      wk_idx <= i;
      wk_go <= 1;
      repeat (3) @(posedge clock);
      wk_go <= 0;
      repeat (4) @(posedge clock);
   endtask
   task automatic pin_reset(logic oe, logic cap);
      cap_low <= cap;
      rst_low <= 1;
      repeat (8) @(posedge clock);
      chk("sys_reset", 1, sys_reset);
      chk("pulldown", 1, wake_cap_pulldown_en);
      chk("rst_oe", oe, reset_input_pin_oe);
      rst_low <= 0;
      cap_low <= 0;
      settle(cap);
   endtask
   task automatic settle(logic quick);
      int n;
      for (n = 0; n < 700 && sys_reset !== 1'b0; n++) @(posedge clock);
      chk("sys_reset", 0, sys_reset);
      chk("quick", quick, n < 100);
      repeat (3) @(posedge clock);
   endtask
   task s_boot;
      apb(0, 8'h04, 0);
      chk("stat", 0, rd);
      apb(0, 8'h0c, 0);
      chk("slverr", 1, err);
      pulse(P_EOI);
      chk("reset_out", 1, reset_output_pin);
   endtask
   task s_idle;
      pulse(P_IDLE);
      chk("cpu", 1, cpu_clk_stop);
      chk("periph", 0, periph_clk_stop);
      pulse(P_IRQ);
      chk("cpu", 0, cpu_clk_stop);
      chk("seen", 3'b010, seen);
      ready_enabled <= 1;
      pulse(P_IDLE);
      chk("cpu", 0, cpu_clk_stop);
      chk("seen", 3'b011, seen);
      ready_enabled <= 0;
      bus_busy <= 1;
      pulse(P_IDLE);
      chk("cpu", 0, cpu_clk_stop);
      bus_busy <= 0;
      repeat (2) @(posedge clock);
      chk("cpu", 1, cpu_clk_stop);
      pulse(P_IRQ);
   endtask
   task s_prot;
      pulse(P_PD);
      chk("periph", 0, periph_clk_stop);
      nmi_pin_n_in <= 0;
      repeat (5) @(posedge clock);
      pulse(P_PD);
      chk("periph", 1, periph_clk_stop);
      chk("osc", 0, osc_pll_stop);
      wake(0);
      chk("periph", 1, periph_clk_stop);
      nmi_pin_n_in <= 1;
      pin_reset(0, 0);
   endtask
   task s_wake;
      apb(1, 8'h00, 32'h21);
      apb(0, 8'h04, 0);
      chk("stat", 32'h10, rd);
      ext_irq_enable <= 8'hff;
      pulse(P_PD);
      chk("osc", 1, osc_pll_stop);
      wake(5);
      chk("osc", 0, osc_pll_stop);
      chk("pulldown", 1, wake_cap_pulldown_en);
      repeat (20) @(posedge clock);
      chk("cpu", 0, cpu_clk_stop);
      chk("svc", 1, seen[2]);
      chk("idx", 5, wake_service_idx);
      ext_irq_enable <= 0;
      pulse(P_PD);
      wake(2);
      repeat (20) @(posedge clock);
      apb(0, 8'h08, 0);
      chk("flag", 32'h400, rd);
      apb(1, 8'h08, 32'h04);
      apb(0, 8'h08, 0);
      chk("flag", 0, rd);
      pin_reset(1, 0);
      apb(0, 8'h00, 0);
      chk("cfg", 0, rd);
      apb(1, 8'h00, 32'h20);
      pulse(P_WDT);
      chk("rst_oe", 1, reset_input_pin_oe);
      settle(0);
      pulse(P_SW);
      chk("sys_reset", 1, sys_reset);
      chk("rst_oe", 0, reset_input_pin_oe);
      settle(0);
      pin_reset(0, 1);
   endtask
   task conclude;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #1000000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge clock);
      reset <= 0;
      repeat (3) @(posedge clock);
      s_boot();
      s_idle();
      s_prot();
      s_wake();
      conclude();
   end
endmodule
`default_nettype wire

// *** verification/rpd_far.sv ***
// Far-side model: reset pin network, wake capacitor, fast pins
`default_nettype none
module rpd_far (
   input  wire logic       rst_low,
   input  wire logic       rst_oe,
   input  wire logic       cap_low,
   input  wire logic       wk_go,
   input  wire logic [2:0] wk_idx,
   output logic            rst_pin,
   output logic            cap_pin,
   output logic [7:0]      fast
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pin has a pullup; either party may pull it low
   assign rst_pin = !(rst_low || rst_oe);
   // Capacitor stays charged unless held discharged
   assign cap_pin = !cap_low;
   // Caller holds wk_go for clocks, well past the minimum width
   assign fast = wk_go ? 8'h01 << wk_idx : 8'h00;
endmodule
`default_nettype wire
